// ### shared/mcrb_pkg.sv
// package: register map, field layout and timing constants of the main clock controller
`default_nettype none
package mcrb_pkg;
  // ----------------------------------------------------------------
  // register word indices; the byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_CLOCK_CTRL_STATUS = 6'h2C;
  localparam logic [5:0] IDX_BEEP_CTRL = 6'h2D;
  localparam logic [5:0] IDX_MODE_CTRL = 6'h2E;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h2F;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h30;
  localparam logic [7:0] ADDR_CLOCK_CTRL_STATUS = {IDX_CLOCK_CTRL_STATUS, 2'b00};
  localparam logic [7:0] ADDR_BEEP_CTRL = {IDX_BEEP_CTRL, 2'b00};
  localparam logic [7:0] RESET_CCS = 8'h00;
  localparam logic [7:0] RESET_BEEP = 8'h00;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_CLOCK_OUT_ENABLE = 7;
  localparam int BIT_DIV_HI = 6;
  localparam int BIT_DIV_LO = 5;
  localparam int BIT_SLOW_MODE = 4;
  localparam int BIT_TB_HI = 3;
  localparam int BIT_TB_LO = 2;
  localparam int BIT_TIMEOUT_IRQ_ENABLE = 1;
  localparam int BIT_TIMEOUT_FLAG = 0;
  localparam int BIT_BEEP_HI = 1;
  localparam int BIT_BEEP_LO = 0;
  localparam int BIT_MODE_WAIT = 0;
  localparam int BIT_MODE_HALT = 1;
  // ----------------------------------------------------------------
  // time base periods in source clock cycles
  // ----------------------------------------------------------------
  localparam logic [17:0] TB_PERIOD_0 = 18'd16000;
  localparam logic [17:0] TB_PERIOD_1 = 18'd32000;
  localparam logic [17:0] TB_PERIOD_2 = 18'd80000;
  localparam logic [17:0] TB_PERIOD_3 = 18'd200000;
  // beep half periods for 2 kHz, 1 kHz and 500 Hz at an 8 MHz source
  localparam logic [13:0] BEEP_HALF_1 = 14'd2000;
  localparam logic [13:0] BEEP_HALF_2 = 14'd4000;
  localparam logic [13:0] BEEP_HALF_3 = 14'd8000;
  // ----------------------------------------------------------------
  // AXI4-Lite answers
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {MCRB_RUN = 2'b00, MCRB_ACTIVE_HALT = 2'b01, MCRB_FULL_HALT = 2'b11} mcrb_power_t;
  typedef struct packed {
    logic clock_out_enable;
    logic [1:0] slow_clock_divider_select;
    logic slow_mode_select;
    logic [1:0] time_base_select;
    logic timeout_irq_enable;
    logic timeout_flag;
  } mcrb_ccs_t;
endpackage
`default_nettype wire

// ### hdl/mcrb_main_clock_ctrl.sv
// main clock controller: prescaler, clock out, time base counter, beeper, AXI4-Lite registers
//
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - slow mode clear: core clock equals source
// - slow divider codes divide by 2,4,8,16
// - clock out enable drives source/2 on pin
// - active halt suspends clock out
// - time base codes: 16000/32000/80000/200000 cycles
// - new time base applies at period end
// - period end sets timeout flag
// - reading status clears flag; writes cannot set
// - irq while flag and enable set
// - halt with enable set enters active halt
// - wait has no effect; timeout wakes it
// - active halt: counter runs, registers frozen except timeout flag set and irq status
// - full halt freezes counter and registers except irq status write-one-clear
// - all status fields reset to zero
// - prescaler, clock out, time base independent
// - beeper drives selected tone on pin
// - beep codes: off, 2k, 1k, 500 Hz
module mcrb_main_clock_ctrl
  import mcrb_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic SYS_CLK, // source clock
  input wire logic RST, // async reset, active high
  input wire logic CLK_EN, // freezes all state while low
  input wire logic HALT_REQ, // pulse: cpu executes halt
  input wire logic WAKE_OTHER, // pulse: another halt-capable wake source
  input wire logic [ADDR_W-1:0] AWADDR, // axi write address
  input wire logic AWVALID, // axi
  output logic AWREADY, // axi
  input wire logic [31:0] WDATA, // axi
  input wire logic [3:0] WSTRB, // axi
  input wire logic WVALID, // axi
  output logic WREADY, // axi
  output logic [1:0] BRESP, // axi
  output logic BVALID, // axi
  input wire logic BREADY, // axi
  input wire logic [ADDR_W-1:0] ARADDR, // axi read address
  input wire logic ARVALID, // axi
  output logic ARREADY, // axi
  output logic [31:0] RDATA, // axi
  output logic [1:0] RRESP, // axi
  output logic RVALID, // axi
  input wire logic RREADY, // axi
  output logic CORE_CLK_EN, // one-cycle core clock enable pulse train
  output logic CLOCK_OUT_PIN, // clock out alternate function level
  output logic CLOCK_OUT_OE_N, // low while clock out drives pin
  output logic BEEP_PIN, // beep square wave
  output logic BEEP_OE_N, // low while beeper drives pin
  output logic IRQ, // timeout interrupt request level
  output logic WAKE, // level: timeout flag and enable set, outside full halt
  output logic [1:0] POWER_STATE // run, active halt, full halt
);
  // the decoder needs address bits 7:2 and widens the address to 32 bits
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W out of range");
  end
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  mcrb_ccs_t ccs_q;
  logic [7:0] beep_q;
  logic [1:0] mask_q;
  logic [1:0] sticky_q;
  mcrb_power_t pwr_q;
  logic [17:0] tb_cnt_q;
  logic [1:0] tb_act_q;
  logic [3:0] pre_cnt_q;
  logic [13:0] beep_cnt_q;
  logic beep_lvl_q;
  logic aw_got_q, w_got_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic core_clk_q, clk_out_q, clk_out_oe_n_q, beep_pin_q, beep_oe_n_q, irq_q, wake_q;

  wire logic regs_live = (pwr_q == MCRB_RUN);
  wire logic cnt_live = (pwr_q != MCRB_FULL_HALT);
  wire logic [17:0] tb_period = (tb_act_q == 2'b00) ? TB_PERIOD_0 :
                                (tb_act_q == 2'b01) ? TB_PERIOD_1 :
                                (tb_act_q == 2'b10) ? TB_PERIOD_2 : TB_PERIOD_3;
  wire logic tb_end = cnt_live && (tb_cnt_q == tb_period - 18'd1);

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  wire logic wr_go = aw_got_q && w_got_q && !BVALID;
  wire logic rd_go = ARVALID && ARREADY;
  wire logic [31:0] aw_addr_w = 32'(aw_addr_q);
  wire logic [31:0] ar_addr_w = 32'(ARADDR);
  wire logic [5:0] wr_idx = aw_addr_w[7:2];
  wire logic [5:0] rd_idx = ar_addr_w[7:2];
  wire logic wr_ok = (aw_addr_w[31:8] == 24'h00_0000) && (wr_idx >= IDX_CLOCK_CTRL_STATUS)
                     && (wr_idx <= IDX_IRQ_MASK);
  wire logic rd_ok = (ar_addr_w[31:8] == 24'h00_0000) && (rd_idx >= IDX_CLOCK_CTRL_STATUS)
                     && (rd_idx <= IDX_IRQ_MASK);
  wire logic rd_ccs = rd_go && rd_ok && (rd_idx == IDX_CLOCK_CTRL_STATUS);
  wire logic wr_lane0 = wr_go && wr_ok && w_strb_q[0] && regs_live;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      BVALID <= 1'b0;
      BRESP <= RESP_OKAY;
    end else if (CLK_EN) begin
      if (AWVALID && AWREADY) begin
        aw_got_q <= 1'b1;
        aw_addr_q <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_got_q <= 1'b1;
        w_data_q <= WDATA;
        w_strb_q <= WSTRB;
      end
      if (wr_go) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        BVALID <= 1'b1;
        BRESP <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end
  assign AWREADY = !aw_got_q && !BVALID;
  assign WREADY = !w_got_q && !BVALID;
  assign ARREADY = !RVALID;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      RVALID <= 1'b0;
      RDATA <= 32'h0000_0000;
      RRESP <= RESP_OKAY;
    end else if (CLK_EN) begin
      if (rd_go) begin
        RVALID <= 1'b1;
        RRESP <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        case (rd_idx)
          IDX_CLOCK_CTRL_STATUS: RDATA <= {24'h00_0000, ccs_q};
          IDX_BEEP_CTRL: RDATA <= {24'h00_0000, beep_q};
          IDX_MODE_CTRL: RDATA <= {30'h0000_0000, pwr_q};
          IDX_IRQ_STATUS: RDATA <= {30'h0000_0000, sticky_q};
          IDX_IRQ_MASK: RDATA <= {30'h0000_0000, mask_q};
          default: RDATA <= 32'h0000_0000;
        endcase
      end else if (RVALID && RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // control/status register
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ccs_q <= RESET_CCS;
    end else if (CLK_EN) begin
      if (wr_lane0 && wr_idx == IDX_CLOCK_CTRL_STATUS) begin
        ccs_q.clock_out_enable <= w_data_q[BIT_CLOCK_OUT_ENABLE];
        ccs_q.slow_clock_divider_select <= w_data_q[BIT_DIV_HI:BIT_DIV_LO];
        ccs_q.slow_mode_select <= w_data_q[BIT_SLOW_MODE];
        ccs_q.time_base_select <= w_data_q[BIT_TB_HI:BIT_TB_LO];
        ccs_q.timeout_irq_enable <= w_data_q[BIT_TIMEOUT_IRQ_ENABLE];
      end
      if (tb_end) begin
        ccs_q.timeout_flag <= 1'b1;
      end else if (rd_ccs && regs_live) begin
        ccs_q.timeout_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      beep_q <= RESET_BEEP;
      mask_q <= 2'b00;
    end else if (CLK_EN && wr_lane0) begin
      if (wr_idx == IDX_BEEP_CTRL) beep_q <= {6'h00, w_data_q[BIT_BEEP_HI:BIT_BEEP_LO]};
      if (wr_idx == IDX_IRQ_MASK) mask_q <= w_data_q[1:0];
    end
  end

  // sticky events: bit 0 timeout, bit 1 wake; write one clears, set wins
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      sticky_q <= 2'b00;
    end else if (CLK_EN) begin
      sticky_q <= (sticky_q & ~((wr_go && wr_ok && w_strb_q[0] && wr_idx == IDX_IRQ_STATUS) ? w_data_q[1:0] : 2'b00))
                  | {wake_q, tb_end};
    end
  end

  // ----------------------------------------------------------------
  // power modes
  // ----------------------------------------------------------------
  wire logic to_wake = ccs_q.timeout_flag && ccs_q.timeout_irq_enable;
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      pwr_q <= MCRB_RUN;
    end else if (CLK_EN) begin
      case (pwr_q)
        MCRB_RUN: begin
          if (HALT_REQ) pwr_q <= ccs_q.timeout_irq_enable ? MCRB_ACTIVE_HALT : MCRB_FULL_HALT;
        end
        MCRB_ACTIVE_HALT: begin
          if (to_wake || WAKE_OTHER) begin
            pwr_q <= MCRB_RUN;
          end
        end
        MCRB_FULL_HALT: begin
          if (WAKE_OTHER) begin
            pwr_q <= MCRB_RUN;
          end
        end
        default: pwr_q <= MCRB_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // time base counter
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      tb_cnt_q <= 18'd0;
      tb_act_q <= 2'b00;
    end else if (CLK_EN && cnt_live) begin
      if (tb_end) begin
        tb_cnt_q <= 18'd0;
        tb_act_q <= ccs_q.time_base_select;
      end else begin
        tb_cnt_q <= tb_cnt_q + 18'd1;
      end
    end
  end

  // ----------------------------------------------------------------
  // core clock prescaler
  // ----------------------------------------------------------------
  wire logic [3:0] div_mask = (ccs_q.slow_clock_divider_select == 2'b00) ? 4'h1 :
                              (ccs_q.slow_clock_divider_select == 2'b01) ? 4'h3 :
                              (ccs_q.slow_clock_divider_select == 2'b10) ? 4'h7 : 4'hF;
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      pre_cnt_q <= 4'h0;
      core_clk_q <= 1'b0;
    end else if (CLK_EN) begin
      pre_cnt_q <= pre_cnt_q + 4'h1;
      if (!ccs_q.slow_mode_select) core_clk_q <= 1'b1;
      else core_clk_q <= ((pre_cnt_q & div_mask) == div_mask);
    end
  end

  // ----------------------------------------------------------------
  // clock out and beeper
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      clk_out_q <= 1'b0;
      clk_out_oe_n_q <= 1'b1;
    end else if (CLK_EN) begin
      clk_out_oe_n_q <= !ccs_q.clock_out_enable;
      clk_out_q <= ccs_q.clock_out_enable && (pwr_q != MCRB_ACTIVE_HALT) && !clk_out_q;
    end
  end

  wire logic [13:0] beep_half = (beep_q[1:0] == 2'b01) ? BEEP_HALF_1 :
                                (beep_q[1:0] == 2'b10) ? BEEP_HALF_2 : BEEP_HALF_3;
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      beep_cnt_q <= 14'd0;
      beep_lvl_q <= 1'b0;
      beep_pin_q <= 1'b0;
      beep_oe_n_q <= 1'b1;
    end else if (CLK_EN) begin
      beep_oe_n_q <= (beep_q[1:0] == 2'b00);
      if (beep_q[1:0] == 2'b00 || pwr_q == MCRB_FULL_HALT) begin
        beep_cnt_q <= 14'd0;
        beep_lvl_q <= 1'b0;
      end else if (beep_cnt_q >= beep_half - 14'd1) begin
        beep_cnt_q <= 14'd0;
        beep_lvl_q <= !beep_lvl_q;
      end else begin
        beep_cnt_q <= beep_cnt_q + 14'd1;
      end
      beep_pin_q <= beep_lvl_q;
    end
  end

  // ----------------------------------------------------------------
  // interrupt and wake outputs
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      irq_q <= 1'b0;
      wake_q <= 1'b0;
    end else if (CLK_EN) begin
      irq_q <= to_wake || |(sticky_q & mask_q);
      wake_q <= to_wake && (pwr_q != MCRB_FULL_HALT);
    end
  end

  assign CORE_CLK_EN = core_clk_q;
  assign CLOCK_OUT_PIN = clk_out_q;
  assign CLOCK_OUT_OE_N = clk_out_oe_n_q;
  assign BEEP_PIN = beep_pin_q;
  assign BEEP_OE_N = beep_oe_n_q;
  assign IRQ = irq_q;
  assign WAKE = wake_q;
  assign POWER_STATE = pwr_q;
endmodule
`default_nettype wire

// ### testbench/mcrb_main_clock_ctrl_properties.sv
// checker: port-level properties of the main clock controller
`timescale 1ns/10ps
`default_nettype none
module mcrb_main_clock_ctrl_properties
  import mcrb_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic SYS_CLK, // clock
  input wire logic RST, // reset
  input wire logic CLK_EN, // clock enable
  input wire logic HALT_REQ, // halt pulse
  input wire logic WAKE_OTHER, // other wake pulse
  input wire logic AWVALID, // axi
  input wire logic AWREADY, // axi
  input wire logic WVALID, // axi
  input wire logic WREADY, // axi
  input wire logic [1:0] BRESP, // axi
  input wire logic BVALID, // axi
  input wire logic BREADY, // axi
  input wire logic ARVALID, // axi
  input wire logic ARREADY, // axi
  input wire logic [31:0] RDATA, // axi
  input wire logic RVALID, // axi
  input wire logic RREADY, // axi
  input wire logic CORE_CLK_EN, // core enable
  input wire logic CLOCK_OUT_PIN, // clock out
  input wire logic CLOCK_OUT_OE_N, // clock out enable
  input wire logic WAKE, // wake
  input wire logic [1:0] POWER_STATE // power state
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST || !CLK_EN);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_clkout_idle: assert property (CLOCK_OUT_OE_N |-> !CLOCK_OUT_PIN)
    else $error("clock out active while disabled");
  a_clkout_toggles: assert property ((!CLOCK_OUT_OE_N && POWER_STATE == MCRB_RUN) [*4]
    |-> CLOCK_OUT_PIN != $past(CLOCK_OUT_PIN)) else $error("clock out not toggling");
  a_halt_clkout_off: assert property (POWER_STATE == MCRB_ACTIVE_HALT [*2] |-> !CLOCK_OUT_PIN)
    else $error("clock out running in active halt");
  a_halt_entry: assert property (HALT_REQ && POWER_STATE == MCRB_RUN
    |-> ##[1:2] POWER_STATE != MCRB_RUN) else $error("halt not entered");
  a_full_halt_quiet: assert property (POWER_STATE == MCRB_FULL_HALT |-> !WAKE)
    else $error("timeout wake in full halt");
  a_other_exit: assert property (POWER_STATE == MCRB_FULL_HALT && WAKE_OTHER
    |-> ##[1:3] POWER_STATE == MCRB_RUN) else $error("full halt not left");
  a_wake_exit: assert property (POWER_STATE == MCRB_ACTIVE_HALT && WAKE
    |-> ##[0:3] POWER_STATE == MCRB_RUN) else $error("active halt not left");
  a_core_pulse: assert property (!CORE_CLK_EN && POWER_STATE == MCRB_RUN
    |-> ##[1:16] (CORE_CLK_EN || POWER_STATE != MCRB_RUN)) else $error("core enable gap too long");
  // both channels taken at one edge: the write runs one edge later, the answer shows after that
  a_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
    else $error("write answer late");
  a_read_answer: assert property (ARVALID && ARREADY |=> RVALID) else $error("read answer late");
  a_read_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data not held");
  a_resp_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response not held");
  // ----------------------------------------------------------------
  // covers
  // ----------------------------------------------------------------
  c_active_wake: cover property (POWER_STATE == MCRB_ACTIVE_HALT ##1 WAKE);
  c_full_exit: cover property (POWER_STATE == MCRB_FULL_HALT ##[1:3] POWER_STATE == MCRB_RUN);
  c_flag_read: cover property (RVALID && RREADY && RDATA[0]);
endmodule
bind mcrb_main_clock_ctrl mcrb_main_clock_ctrl_properties #(.ADDR_W(ADDR_W)) u_props (.SYS_CLK, .RST, .CLK_EN,
  .HALT_REQ, .WAKE_OTHER, .AWVALID, .AWREADY, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARVALID,
  .ARREADY, .RDATA, .RVALID, .RREADY, .CORE_CLK_EN, .CLOCK_OUT_PIN, .CLOCK_OUT_OE_N, .WAKE, .POWER_STATE);
`default_nettype wire

// ### testbench/test_main_clock_rtc_beeper.sv
// testbench: registers, prescaler, clock out, time base, halt modes and beeper
`timescale 1ns/10ps
`default_nettype none
module test_main_clock_rtc_beeper
  import mcrb_pkg::*;
;
  logic sys_clk, rst, halt_req, wake_other, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, core_clk_en, clock_out_pin, clock_out_oe_n;
  logic beep_pin, beep_oe_n, irq, wake, clk_en;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, power_state, r;
  integer fail_count, tests_run, seed, t0, t1, g, ccs_m;
  integer cyc = 0;
  localparam logic [7:0] A_MODE = {IDX_MODE_CTRL, 2'b00};
  localparam logic [7:0] A_STATUS = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [7:0] A_MASK = {IDX_IRQ_MASK, 2'b00};
  localparam logic [7:0] A_NONE = A_MASK + 8'h04;
  mcrb_main_clock_ctrl uut (.SYS_CLK(sys_clk), .RST(rst), .CLK_EN(clk_en), .HALT_REQ(halt_req),
    .WAKE_OTHER(wake_other), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
    .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
    .RREADY(rready), .CORE_CLK_EN(core_clk_en), .CLOCK_OUT_PIN(clock_out_pin), .CLOCK_OUT_OE_N(clock_out_oe_n),
    .BEEP_PIN(beep_pin), .BEEP_OE_N(beep_oe_n), .IRQ(irq), .WAKE(wake), .POWER_STATE(power_state));
  initial begin
    sys_clk = 0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) cyc <= cyc + 1;
  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'($random(seed)) | 4'h1;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    forever begin
      @(posedge sys_clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    forever begin
      @(posedge sys_clk);
      if (arready) arvalid <= 0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 0;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic pulse(input bit other);
    @(posedge sys_clk);
    if (other) wake_other <= 1;
    else halt_req <= 1;
    @(posedge sys_clk);
    wake_other <= 0;
    halt_req <= 0;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge sys_clk);
    fail_count++;
    results;
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h4126;
    fail_count = 0;
    tests_run = 0;
    rst = 1;
    clk_en = 1;
    {halt_req, wake_other, awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = '0;
    repeat (12) @(posedge sys_clk);
    rst <= 0;
    t0 = cyc;
    rd(ADDR_CLOCK_CTRL_STATUS); chk("ccs reset", 32'h0000_0000, d);
    rd(ADDR_BEEP_CTRL); chk("beep reset", 32'h0000_0000, d);
    chk("core clk normal", 1, core_clk_en);
    $display("test reset finished");
    ccs_m = 8'h86;
    wr(ADDR_CLOCK_CTRL_STATUS, ccs_m | ($random(seed) & 32'hFFFF_FF01));
    rd(ADDR_CLOCK_CTRL_STATUS); chk("ccs written", ccs_m, d);
    chk("clock out oe", 0, clock_out_oe_n);
    g = clock_out_pin;
    @(posedge sys_clk); chk("clock out toggle", !g, clock_out_pin);
    // clock enable low for five edges: every output and counter holds
    clk_en <= 0;
    @(posedge sys_clk);
    g = clock_out_pin;
    repeat (4) @(posedge sys_clk);
    chk("clock out frozen", g, clock_out_pin);
    clk_en <= 1;
    t0 = t0 + 5;
    for (int c = 0; c < 4; c++) begin
      ccs_m = 8'h96 | (c << 5);
      wr(ADDR_CLOCK_CTRL_STATUS, ccs_m);
      repeat (3) begin
        @(posedge sys_clk);
        while (core_clk_en !== 1) @(posedge sys_clk);
        t1 = cyc;
      end
      @(posedge sys_clk);
      while (core_clk_en !== 1) @(posedge sys_clk);
      chk("core clk gap", 2 << c, cyc - t1);
    end
    $display("test prescaler finished");
    for (int c = 3; c >= 0; c--) begin
      wr(ADDR_BEEP_CTRL, ($random(seed) & 32'h0000_00F0) | c);
      rd(ADDR_BEEP_CTRL); chk("beep code", c, d[1:0]);
      repeat (2) @(posedge sys_clk);
      chk("beep oe", c == 0, beep_oe_n);
    end
    // the loop ends with the tone off; measure the highest tone
    wr(ADDR_BEEP_CTRL, 32'h0000_0001);
    g = beep_pin;
    while (beep_pin === g) @(posedge sys_clk);
    t1 = cyc;
    while (beep_pin !== g) @(posedge sys_clk);
    chk("beep half period", 1, cyc - t1 >= 1999 && cyc - t1 <= 2001);
    $display("test beeper finished");
    while (irq !== 1) @(posedge sys_clk);
    t1 = cyc;
    chk("first period", 1, t1 - t0 >= 15996 && t1 - t0 <= 16008);
    rd(ADDR_CLOCK_CTRL_STATUS); chk("flag read", ccs_m | 1, d);
    rd(ADDR_CLOCK_CTRL_STATUS); chk("flag cleared", ccs_m, d);
    repeat (2) @(posedge sys_clk); chk("irq after clear", 0, irq);
    rd(A_STATUS); chk("sticky timeout", 1, d[0]);
    chk("sticky wake", 1, d[1]);
    wr(A_MASK, 32'h0000_0001);
    repeat (2) @(posedge sys_clk); chk("irq masked in", 1, irq);
    wr(A_STATUS, 32'h0000_0001);
    repeat (2) @(posedge sys_clk); chk("irq sticky cleared", 0, irq);
    rd(A_MODE); chk("power state run", 0, d);
    rd(A_NONE); chk("unmapped resp", RESP_SLVERR, r);
    chk("unmapped data", 0, d);
    $display("test time base finished");
    pulse(0); chk("active halt", MCRB_ACTIVE_HALT, power_state);
    g = 0;
    repeat (8) begin
      @(posedge sys_clk);
      g = g | clock_out_pin;
    end
    chk("clock out in halt", 0, g);
    wr(ADDR_CLOCK_CTRL_STATUS, 32'h0000_0000); chk("frozen write resp", RESP_OKAY, r);
    while (power_state !== MCRB_RUN) @(posedge sys_clk);
    chk("second period", 1, cyc - t1 >= 31996 && cyc - t1 <= 32010);
    rd(ADDR_CLOCK_CTRL_STATUS); chk("ccs frozen", ccs_m | 1, d);
    $display("test active halt finished");
    wr(ADDR_CLOCK_CTRL_STATUS, 32'h0000_0004);
    pulse(0); chk("full halt", MCRB_FULL_HALT, power_state);
    repeat (40) @(posedge sys_clk);
    chk("full halt held", MCRB_FULL_HALT, power_state);
    pulse(1); chk("full halt exit", MCRB_RUN, power_state);
    $display("test full halt finished");
    results;
  end
endmodule
`default_nettype wire
